//--- hw/dspsv_pkg.sv
// Package for the data-space and program-visibility access block
package dspsv_pkg;
  localparam int EA_W = 16;
  localparam int DATA_W = 16;
  localparam int PWORD_W = 24;
  localparam int PADDR_W = 24;
  localparam int PAGE_W = 8;
  localparam int WIN_OFS_W = 15;
  localparam logic [15:0] ZERO_WORD = 16'h0000;
  localparam logic [15:0] PTR_STEP_BYTE = 16'h0001;
  localparam logic [15:0] PTR_STEP_WORD = 16'h0002;
  localparam logic [1:0] PEN_NONE = 2'h0;
  localparam logic [1:0] PEN_ONE = 2'h1;
  localparam logic [1:0] PEN_TWO = 2'h2;
  localparam logic [15:0] RAM_WORDS_RST = 16'h1000;

  typedef enum logic [1:0] {
    DSPSV_CLS_OTHER = 2'b00,
    DSPSV_CLS_MAC = 2'b01,
    DSPSV_CLS_XFER = 2'b10,
    DSPSV_CLS_DXFER = 2'b11
  } dspsv_class_t;

  typedef enum logic [1:0] {
    DSPSV_ST_IDLE = 2'b00,
    DSPSV_ST_FETCH = 2'b01,
    DSPSV_ST_DONE = 2'b10
  } dspsv_state_t;

  typedef struct packed {
    logic valid;
    logic wr;
    logic byte_op;
    logic y_path;
    logic x_prefetch_ptr;
    logic y_prefetch_ptr;
    dspsv_class_t iclass;
    logic in_loop;
    logic loop_edge;
    logic table_op;
    logic [15:0] effective_address;
    logic [15:0] wdata;
    logic [15:0] source_pointer_reg;
    logic post_inc;
  } dspsv_req_t;

  typedef struct packed {
    logic done;
    logic [15:0] rdata;
    logic addr_error;
    logic [1:0] extra_cycles;
    logic [15:0] next_pointer;
  } dspsv_rsp_t;
endpackage

//--- hw/dspsv_access.sv
// Data-space access unit with program-space visibility window
// Contract
// - Upper half of data space maps onto a selectable 16K-word program page.
// - Program space is used only when address MSb and visibility enable set.
// - Each window access adds zero, one or two wait cycles, set by class and loop position.
// - Window reads return only the low 16 bits of the program word.
// - Program address is page register bits above 15 address bits.
// - Window mapping is suspended during table read or write instructions.
// - Outside loops, MAC prefetch and transfers through window cost one cycle.
// - Outside loops, other window instructions cost two extra cycles.
// - In loops, first, last, interrupt exit and re-entry cost two cycles.
// - Other loop iterations through the window cost nothing extra.
// - Unimplemented address reads zero and raises an address error.
// - MAC X pointer into Y or Y pointer into X returns zero.
// - Effective addresses are 16 bits and select bytes, 64 Kbytes.
// - Data path and memory are 16-bit words, byte addressable.
// - Byte read picks byte by address LSb onto low X lane.
// - Y path carries word accesses only.
// - Byte write drives only the matching lane strobe.
// - Post-increment adds one for bytes and two for words.
// - Window accesses occur only on the X path.
// - Program address steps by two per program word.
`timescale 1ns/1ps
module dspsv_access #(
  parameter logic [15:0] RAM_WORDS = dspsv_pkg::RAM_WORDS_RST,
  parameter logic [15:0] Y_BASE = 16'h0800
) (
  input wire logic mclk,
  input wire logic rst,
  input wire dspsv_pkg::dspsv_req_t req,
  input wire logic visibility_enable,
  input wire logic [7:0] visibility_page_register,
  output logic [23:0] prog_addr,
  output logic prog_rd,
  input wire logic [23:0] prog_rdata,
  output logic [14:0] ram_addr,
  output logic ram_rd,
  output logic [1:0] ram_we,
  output logic [15:0] ram_wdata,
  input wire logic [15:0] ram_rdata,
  output dspsv_pkg::dspsv_rsp_t rsp
);

  // Word index of a byte address, shared decode for both lanes
  function automatic logic [14:0] word_index(input logic [15:0] a);
    word_index = a[15:1];
  endfunction

  // Byte lane strobes from access size and address LSb
  function automatic logic [1:0] lanes(input logic byte_op, input logic [15:0] a);
    if (!byte_op) begin
      lanes = 2'h3;
    end else if (a[0]) begin
      lanes = 2'h2;
    end else begin
      lanes = 2'h1;
    end
  endfunction

  dspsv_pkg::dspsv_state_t state;
  dspsv_pkg::dspsv_req_t held;
  logic win_hit;
  logic unimpl;
  logic space_clash;
  logic [1:0] penalty;
  logic [1:0] wait_cnt;
  logic [23:0] win_addr;

  // Table instructions reach flash on their own path, so no window then
  assign win_hit = req.effective_address[15] & visibility_enable & ~req.table_op
                   & ~req.y_path;
  // Ordinary data space below the window, or the whole map when disabled, for table ops or on the Y path
  assign unimpl = ~win_hit & (word_index(req.effective_address) >= RAM_WORDS[14:0]);
  assign space_clash = (req.iclass == dspsv_pkg::DSPSV_CLS_MAC) &
                       ((req.x_prefetch_ptr & (req.effective_address >= Y_BASE)) |
                        (req.y_prefetch_ptr & (req.effective_address < Y_BASE)));
  // Low 15 address bits pass, page fills above; bit 0 keeps step of two
  assign win_addr = {1'b0, visibility_page_register, req.effective_address[14:0]};

  always_comb begin
    penalty = dspsv_pkg::PEN_NONE;
    if (win_hit) begin
      if (req.in_loop && !req.loop_edge) begin
        penalty = dspsv_pkg::PEN_NONE;
      end else if (req.in_loop) begin
        penalty = dspsv_pkg::PEN_TWO;
      end else if (req.iclass == dspsv_pkg::DSPSV_CLS_OTHER) begin
        penalty = dspsv_pkg::PEN_TWO;
      end else begin
        penalty = dspsv_pkg::PEN_ONE;
      end
    end
  end

  // Access sequencer
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      state <= dspsv_pkg::DSPSV_ST_IDLE;
      held <= '0;
      wait_cnt <= 2'h0;
    end else begin
      case (state)
        dspsv_pkg::DSPSV_ST_IDLE: begin
          if (req.valid) begin
            held <= req;
            wait_cnt <= penalty;
            state <= dspsv_pkg::DSPSV_ST_FETCH;
          end
        end
        dspsv_pkg::DSPSV_ST_FETCH: begin
          if (wait_cnt == 2'h0) begin
            state <= dspsv_pkg::DSPSV_ST_DONE;
          end else begin
            wait_cnt <= wait_cnt - 2'h1;
          end
        end
        dspsv_pkg::DSPSV_ST_DONE: begin
          state <= dspsv_pkg::DSPSV_ST_IDLE;
        end
        default: begin
          state <= dspsv_pkg::DSPSV_ST_IDLE;
        end
      endcase
    end
  end

  logic held_win;
  logic held_zero;
  logic held_err;
  logic [1:0] held_pen;

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      held_win <= 1'b0;
      held_zero <= 1'b0;
      held_err <= 1'b0;
      held_pen <= 2'h0;
    end else if (state == dspsv_pkg::DSPSV_ST_IDLE && req.valid) begin
      held_win <= win_hit;
      held_zero <= unimpl | space_clash;
      held_err <= unimpl;
      held_pen <= penalty;
    end
  end

  // Memory strobes, held stable through the fetch state
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      prog_addr <= 24'h000000;
      prog_rd <= 1'b0;
      ram_addr <= 15'h0000;
      ram_rd <= 1'b0;
      ram_we <= 2'h0;
      ram_wdata <= 16'h0000;
    end else if (state == dspsv_pkg::DSPSV_ST_IDLE && req.valid) begin
      prog_addr <= win_addr;
      prog_rd <= win_hit & ~req.wr;
      ram_addr <= word_index(req.effective_address);
      ram_rd <= ~win_hit & ~unimpl & ~space_clash & ~req.wr;
      // Y path never does byte access
      ram_we <= (~win_hit & ~unimpl & req.wr) ?
                lanes(req.byte_op & ~req.y_path, req.effective_address) : 2'h0;
      ram_wdata <= (req.byte_op && req.effective_address[0]) ?
                   {req.wdata[7:0], req.wdata[7:0]} : req.wdata;
    end else if (state == dspsv_pkg::DSPSV_ST_DONE) begin
      prog_rd <= 1'b0;
      ram_rd <= 1'b0;
      ram_we <= 2'h0;
    end
  end

  logic [15:0] word_data;
  logic [15:0] read_value;

  always_comb begin
    word_data = held_win ? prog_rdata[15:0] : ram_rdata;
    read_value = word_data;
    if (held_zero) begin
      read_value = dspsv_pkg::ZERO_WORD;
    end else if (held.byte_op && !held.y_path) begin
      read_value = {8'h00, held.effective_address[0] ? word_data[15:8] : word_data[7:0]};
    end
  end

  // Answer registered on the edge that ends the fetch, together with the step into the done state
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      rsp <= '0;
    end else begin
      rsp.done <= (state == dspsv_pkg::DSPSV_ST_FETCH) && (wait_cnt == 2'h0);
      rsp.addr_error <= (state == dspsv_pkg::DSPSV_ST_FETCH) && (wait_cnt == 2'h0) &&
                        held_err;
      if (state == dspsv_pkg::DSPSV_ST_FETCH && wait_cnt == 2'h0) begin
        rsp.rdata <= held.wr ? dspsv_pkg::ZERO_WORD : read_value;
        rsp.extra_cycles <= held_pen;
        rsp.next_pointer <= !held.post_inc ? held.source_pointer_reg :
                            held.source_pointer_reg + (held.byte_op ?
                            dspsv_pkg::PTR_STEP_BYTE : dspsv_pkg::PTR_STEP_WORD);
      end
    end
  end

endmodule

//--- verif/dspsv_props.sv
// Port checker for the data-space access unit
`timescale 1ns/1ps
module dspsv_props (
  input wire logic mclk,
  input wire logic rst,
  input wire dspsv_pkg::dspsv_req_t req,
  input wire logic visibility_enable,
  input wire logic [7:0] visibility_page_register,
  input wire logic [23:0] prog_addr,
  input wire logic prog_rd,
  input wire logic [23:0] prog_rdata,
  input wire logic ram_rd,
  input wire logic [1:0] ram_we,
  input wire dspsv_pkg::dspsv_rsp_t rsp
);
  default clocking @(posedge mclk); endclocking
  default disable iff (rst);
  a_page_form: assert property (prog_rd |-> prog_addr[23:15] == {1'h0, visibility_page_register})
    else $error("window address not built from page");
  a_window_gate: assert property ($rose(prog_rd) |->
    $past(req.effective_address[15] && visibility_enable && !req.table_op && !req.y_path))
    else $error("window fetch without its conditions");
  a_one_space: assert property (!(prog_rd && (ram_rd || (|ram_we))))
    else $error("flash and RAM strobed together");
  a_byte_lane: assert property ($rose(|ram_we) && $past(req.byte_op) |->
    ram_we == (2'h1 << $past(req.effective_address[0])))
    else $error("wrong byte lane strobed");
  a_low_word: assert property (rsp.done && prog_rd |-> rsp.rdata == $past(prog_rdata[15:0]))
    else $error("window data not low program word");
  a_done_bound: assert property ($rose(prog_rd || ram_rd || (|ram_we)) |-> ##[1:3] rsp.done)
    else $error("answer missing");
  a_two_fetch: assert property ($rose(prog_rd) |-> prog_rd [*2])
    else $error("window fetch too short");
  a_err_zero: assert property (rsp.addr_error |-> rsp.done && rsp.rdata == 16'h0000)
    else $error("address error without zero answer");
  c_pen_two: cover property (rsp.done && rsp.extra_cycles == 2'h2);
  c_pen_none: cover property (rsp.done && prog_rd && rsp.extra_cycles == 2'h0);
  c_err: cover property (rsp.addr_error);
endmodule
bind dspsv_access dspsv_props i_dspsv_props (.mclk, .rst, .req, .visibility_enable,
  .visibility_page_register, .prog_addr, .prog_rd, .prog_rdata, .ram_rd, .ram_we, .rsp);

//--- verif/dspsv_mem_model.sv
// Flash and RAM stand-ins on the far side of the access unit
`timescale 1ns/1ps
module dspsv_mem_model (
  input wire logic mclk,
  input wire logic [23:0] prog_addr,
  input wire logic prog_rd,
  output logic [23:0] prog_rdata,
  input wire logic [14:0] ram_addr,
  input wire logic ram_rd,
  output logic [15:0] ram_rdata
);
  logic tog = 1'h0;
  always @(posedge mclk) tog <= ~tog;
  // Idle buses flicker so stale data cannot pass; program word upper byte set to expose leaks
  assign prog_rdata = prog_rd ? {8'hFF, prog_addr[22:7]} : {24{tog}};
  assign ram_rdata = ram_rd ? {ram_addr, 1'h1} : {16{~tog}};
endmodule

//--- verif/data_space_psv_access_test.sv
// Self-checking bench for the data-space access unit
`timescale 1ns/1ps
`define CHK(a, b) begin checks_done++; if ((a) !== (b)) begin n_mismatch++; \
  $display("[FAIL] %0t got %h want %h", $time, a, b); end end
module data_space_psv_access_test;
  typedef struct packed {
    logic en; logic [7:0] pg; logic [1:0] cls; logic byt, xp, yp, ym, lp, edg, tbl;
    logic [15:0] ea; logic [15:0] rd; logic [1:0] ex; logic er;
  } dspsv_row_t;
  logic mclk, rst, visibility_enable, prog_rd, ram_rd;
  logic [7:0] visibility_page_register;
  logic [23:0] prog_addr, prog_rdata;
  logic [14:0] ram_addr;
  logic [1:0] ram_we;
  logic [15:0] ram_wdata, ram_rdata;
  dspsv_pkg::dspsv_req_t req;
  dspsv_pkg::dspsv_rsp_t rsp;
  int n_mismatch = 0, checks_done = 0, cyc = 0, n;
  dspsv_row_t rows [15] = '{
    '{1, 8'h5A, 0, 0, 0, 0, 0, 0, 0, 0, 16'h8123, 16'h5A02, 2, 0},
    '{1, 8'h03, 1, 0, 0, 0, 0, 0, 0, 0, 16'hC0FE, 16'h0381, 1, 0},
    '{1, 8'h01, 2, 0, 0, 0, 0, 0, 0, 0, 16'h8002, 16'h0100, 1, 0},
    '{1, 8'h02, 3, 0, 0, 0, 0, 0, 0, 0, 16'hFFFE, 16'h02FF, 1, 0},
    '{1, 8'h01, 0, 0, 0, 0, 0, 1, 0, 0, 16'h8080, 16'h0101, 0, 0},
    '{1, 8'h01, 2, 0, 0, 0, 0, 1, 1, 0, 16'h8000, 16'h0100, 2, 0},
    '{0, 8'h01, 0, 0, 0, 0, 0, 0, 0, 0, 16'h8010, 16'h8011, 0, 0},
    '{1, 8'h01, 0, 0, 0, 0, 0, 0, 0, 1, 16'h8010, 16'h8011, 0, 0},
    '{0, 8'h00, 0, 1, 0, 0, 0, 0, 0, 0, 16'h1234, 16'h0035, 0, 0},
    '{0, 8'h00, 0, 1, 0, 0, 0, 0, 0, 0, 16'h1235, 16'h0012, 0, 0},
    '{0, 8'h00, 0, 0, 0, 0, 0, 0, 0, 0, 16'hC010, 16'h0000, 0, 1},
    '{0, 8'h00, 1, 0, 1, 0, 0, 0, 0, 0, 16'h0900, 16'h0000, 0, 0},
    '{0, 8'h00, 1, 0, 0, 1, 1, 0, 0, 0, 16'h0100, 16'h0000, 0, 0},
    '{0, 8'h00, 1, 1, 0, 1, 1, 0, 0, 0, 16'h0901, 16'h0901, 0, 0},
    '{1, 8'h01, 1, 0, 0, 1, 1, 0, 0, 0, 16'h8800, 16'h8801, 0, 0}};
  dspsv_access #(.RAM_WORDS(16'h6000)) i_dspsv_access (.mclk, .rst, .req, .visibility_enable,
    .visibility_page_register, .prog_addr, .prog_rd, .prog_rdata, .ram_addr, .ram_rd, .ram_we,
    .ram_wdata, .ram_rdata, .rsp);
  dspsv_mem_model i_dspsv_mem_model (.mclk, .prog_addr, .prog_rd, .prog_rdata, .ram_addr,
    .ram_rd, .ram_rdata);
  task automatic summarize();
    $display("mismatches %0d, checks %0d", n_mismatch, checks_done);
    if (n_mismatch == 0 && checks_done > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  // Request held for the accepting edge only; latency counted in cycles
  task automatic run(input dspsv_row_t r, input logic wr);
    @(negedge mclk);
    visibility_enable = r.en;
    visibility_page_register = r.pg;
    req = '{1'h1, wr, r.byt, r.ym, r.xp, r.yp, dspsv_pkg::dspsv_class_t'(r.cls), r.lp, r.edg,
      r.tbl, r.ea, 16'hA55A, 16'h0100, 1'h1};
    @(negedge mclk);
    req.valid = 1'h0;
    n = 0;
    while (rsp.done !== 1'h1 && n < 12) begin
      @(negedge mclk);
      n++;
    end
  endtask
  initial begin
    mclk = 1'h0;
    forever #5 mclk = ~mclk;
  end
  always @(posedge mclk) begin
    cyc++;
    if (cyc == 3000) begin
      n_mismatch++;
      summarize();
    end
  end
  initial begin
    rst = 1'h1;
    req = '0;
    visibility_enable = 1'h0;
    visibility_page_register = 8'h00;
    repeat (3) @(negedge mclk);
    `CHK(rsp, 36'h0)
    `CHK({prog_rd, ram_rd, ram_we}, 4'h0)
    rst = 1'h0;
    foreach (rows[i]) begin
      run(rows[i], 1'h0);
      `CHK(n, 1 + rows[i].ex)
      `CHK(rsp.extra_cycles, rows[i].ex)
      `CHK(rsp.rdata, rows[i].rd)
      `CHK(rsp.addr_error, rows[i].er)
    end
    run('{0, 8'h00, 0, 1, 0, 0, 0, 0, 0, 0, 16'h1235, 16'h0000, 0, 0}, 1'h1);
    `CHK(rsp.next_pointer, 16'h0101)
    `CHK(ram_we, 2'h2)
    `CHK(ram_wdata, 16'h5A5A)
    run('{0, 8'h00, 0, 0, 0, 0, 0, 0, 0, 0, 16'h1236, 16'h0000, 0, 0}, 1'h1);
    `CHK(rsp.next_pointer, 16'h0102)
    `CHK(n, 1)
    `CHK(ram_we, 2'h3)
    `CHK(ram_wdata, 16'hA55A)
    summarize();
  end
endmodule
